/* File: common/flash_program_strobe_n_cfg.svh */
`ifndef FLASH_PROGRAM_STROBE_N_CFG_SVH
`define FLASH_PROGRAM_STROBE_N_CFG_SVH

// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define FP_ARRAY_BYTES 4096
`define FP_ADDR_W 12
`define FP_BLANK_BYTE 8'hff
`define FP_ADDR_ZERO 12'h000
`define FP_ADDR_STEP 12'h001

// ------------------------------------------------------------
// mode pin codes, bit n is mode_select_n
// ------------------------------------------------------------
`define FP_MODE_WRITE 4'he
`define FP_MODE_LOCK1 4'hf
`define FP_MODE_LOCK2 4'h3
`define FP_MODE_ERASE 4'h1
`define FP_MODE_READ 4'hc
`define FP_MODE_SIG 4'h0

// ------------------------------------------------------------
// signature locations
// ------------------------------------------------------------
`define FP_SIG_MAKER_ADDR 12'h000
`define FP_SIG_PART_ADDR 12'h001
`define FP_SIG_EXTRA_ADDR 12'h002

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FP_CLK_NS 4
`define FP_WRITE_NS 1200000
`define FP_WRITE_MAX_NS 2000000
`define FP_ERASE_NS 10000000
`define FP_SETUP_NS 10000
`define FP_STEP_NS 1000
`define FP_PULSE_NS 2000
`define FP_WRITE_CYC ((`FP_WRITE_NS) / (`FP_CLK_NS))
`define FP_ERASE_CYC (((`FP_ERASE_NS) + (`FP_CLK_NS) - 1) / (`FP_CLK_NS))
`define FP_SETUP_CYC (((`FP_SETUP_NS) + (`FP_CLK_NS) - 1) / (`FP_CLK_NS))
`define FP_STEP_CYC (((`FP_STEP_NS) + (`FP_CLK_NS) - 1) / (`FP_CLK_NS))
`define FP_PULSE_CYC (((`FP_PULSE_NS) + (`FP_CLK_NS) - 1) / (`FP_CLK_NS))

// ------------------------------------------------------------
// programmer registers
// ------------------------------------------------------------
`define FP_REG_CMD 4'h0
`define FP_REG_STATUS 4'h4

`endif

/* File: common/flash_program_strobe_n_pkg.sv */
package flash_program_strobe_n_pkg;

   // ---------------------------------------------------------
   // device side
   // ---------------------------------------------------------
   typedef enum logic [0:0] {DEV_IDLE = 1'b0, DEV_BUSY = 1'b1} dev_state_e;
   typedef enum logic [1:0] {OP_CODE = 2'b00, OP_LOCK1 = 2'b01, OP_LOCK2 = 2'b10} dev_op_e;

   typedef struct packed {
      logic rst_pin;
      logic vpp_pin;
      logic osc;
      logic strobe_n;
      logic [3:0] mode;
      logic [7:0] data;
   } pin_s;

   typedef struct packed {
      pin_s s1;
      pin_s s2;
      pin_s s3;
      pin_s filt;
      dev_state_e state;
      dev_op_e op;
      logic [11:0] addr;
      logic [11:0] waddr;
      logic [7:0] wdata;
      logic [31:0] cnt;
      logic [31:0] low_cnt;
      logic lock_bit_one;
      logic lock_bit_two;
      logic busy;
      logic [7:0] dout;
      logic doe;
   } dev_s;

   // ---------------------------------------------------------
   // programmer side
   // ---------------------------------------------------------
   typedef enum logic [2:0] {
      PS_IDLE = 3'b000,
      PS_SETUP = 3'b001,
      PS_ARM = 3'b010,
      PS_ACTIVE = 3'b011,
      PS_WAIT_RDY = 3'b100,
      PS_HOLD = 3'b101
   } prg_state_e;

   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_POWER_UP = 4'h1,
      CMD_WRITE_CODE = 4'h2,
      CMD_WRITE_LOCK1 = 4'h3,
      CMD_WRITE_LOCK2 = 4'h4,
      CMD_ERASE = 4'h5,
      CMD_READ_CODE = 4'h6,
      CMD_READ_SIG = 4'h7,
      CMD_INCREMENT = 4'h8,
      CMD_CLEAR_ADDR = 4'h9,
      CMD_POWER_OFF = 4'ha
   } cmd_e;

   typedef struct packed {
      logic [8:0] s1;
      logic [8:0] s2;
      logic [8:0] s3;
      logic [8:0] filt;
      prg_state_e state;
      cmd_e cmd;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [31:0] cnt;
      logic rst_pin;
      logic vpp_pin;
      logic osc;
      logic strobe_on;
      logic [3:0] mode;
      logic doe;
   } prg_s;

endpackage

/* File: common/fp_link_if.sv */
`timescale 1ns/100ps
`include "flash_program_strobe_n_cfg.svh"
interface fp_link_if;
   logic rst_pin;
   logic vpp_pin;
   logic osc_pin;
   logic program_strobe_n;
   logic [3:0] mode_select;
   logic [7:0] data_p2d;
   logic data_p2d_oe;
   logic [7:0] data_d2p;
   logic data_d2p_oe;
   logic ready_busy_n;
   logic [7:0] data_line;

   // resolved data port, pulled high when nobody drives
   assign data_line = data_d2p_oe ? data_d2p : (data_p2d_oe ? data_p2d : `FP_BLANK_BYTE);

   modport device (
      input rst_pin, vpp_pin, osc_pin, program_strobe_n, mode_select, data_line,
      output data_d2p, data_d2p_oe, ready_busy_n
   );
   modport programmer (
      output rst_pin, vpp_pin, osc_pin, program_strobe_n, mode_select, data_p2d, data_p2d_oe,
      input data_line, ready_busy_n
   );
endinterface // fp_link_if

/* File: verilog/flash_program_strobe_n_device.sv */
`timescale 1ns/100ps
`include "flash_program_strobe_n_cfg.svh"
// ------------------------------------------------------------
// ------------------------------------------------------------
module flash_program_strobe_n_device
#(
   parameter int WRITE_CYCLES = `FP_WRITE_CYC,
   parameter int ERASE_CYCLES = `FP_ERASE_CYC,
   parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
   parameter logic [7:0] PART_CODE = 8'ha5, // arbitrary value
   parameter logic [7:0] EXTRA_CODE = 8'h3c // arbitrary value
)
(
   input wire logic I_CLK,
   input wire logic I_RST,
   fp_link_if.device LINK,
   output logic O_BUSY
);
   import flash_program_strobe_n_pkg::*;

   // ---------------------------------------------------------
   // declarations
   // ---------------------------------------------------------
   logic [7:0] mem [`FP_ARRAY_BYTES];
   dev_s st_reg;
   dev_s st_next;
   pin_s agree;
   pin_s f;
   logic [7:0] mem_rd;
   logic mem_we;
   logic mem_erase;
   logic rise_rst;
   logic rise_osc;
   logic rise_prg;
   logic start;
   dev_op_e start_op;
   logic rd_code;
   logic rd_sig;
   logic locked_any;

   assign mem_rd = mem[st_reg.addr];

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      mem_we = 1'b0;
      mem_erase = 1'b0;
      start = 1'b0;
      start_op = OP_CODE;

      // three-stage pin sampling, a change counts once stages two and three agree
      st_next.s1.rst_pin = LINK.rst_pin;
      st_next.s1.vpp_pin = LINK.vpp_pin;
      st_next.s1.osc = LINK.osc_pin;
      st_next.s1.strobe_n = LINK.program_strobe_n;
      st_next.s1.mode = LINK.mode_select;
      st_next.s1.data = LINK.data_line;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      agree = ~(st_reg.s2 ^ st_reg.s3);
      st_next.filt = (agree & st_reg.s3) | (~agree & st_reg.filt);
      f = st_next.filt;

      rise_rst = f.rst_pin & ~st_reg.filt.rst_pin;
      rise_osc = f.osc & ~st_reg.filt.osc;
      rise_prg = f.strobe_n & ~st_reg.filt.strobe_n;

      // address counter
      if (rise_rst)
      begin
         st_next.addr = `FP_ADDR_ZERO;
      end
      else if (rise_osc)
      begin
         st_next.addr = st_reg.addr + `FP_ADDR_STEP;
      end

      // erase strobe low time
      if (!f.strobe_n && f.vpp_pin && f.mode == `FP_MODE_ERASE)
      begin
         if (st_reg.low_cnt != 32'hffffffff)
         begin
            st_next.low_cnt = st_reg.low_cnt + 32'h00000001;
         end
      end
      else
      begin
         st_next.low_cnt = 32'h00000000;
      end

      unique case (st_reg.state)
         DEV_IDLE:
         begin
            if (rise_prg && f.vpp_pin && f.rst_pin)
            begin
               if (f.mode == `FP_MODE_WRITE && !st_reg.lock_bit_one)
               begin
                  start = 1'b1;
                  start_op = OP_CODE;
               end
               else if (f.mode == `FP_MODE_LOCK1)
               begin
                  start = 1'b1;
                  start_op = OP_LOCK1;
               end
               else if (f.mode == `FP_MODE_LOCK2)
               begin
                  start = 1'b1;
                  start_op = OP_LOCK2;
               end
               else if (f.mode == `FP_MODE_ERASE && st_reg.low_cnt >= 32'(ERASE_CYCLES))
               begin
                  mem_erase = 1'b1;
                  st_next.lock_bit_one = 1'b0;
                  st_next.lock_bit_two = 1'b0;
               end
            end
            if (start)
            begin
               st_next.state = DEV_BUSY;
               st_next.op = start_op;
               st_next.cnt = 32'h00000000;
               st_next.waddr = st_reg.addr;
               st_next.wdata = f.data;
               st_next.busy = 1'b1;
            end
         end
         DEV_BUSY:
         begin
            st_next.cnt = st_reg.cnt + 32'h00000001;
            if (st_reg.cnt >= 32'(WRITE_CYCLES - 1))
            begin
               st_next.state = DEV_IDLE;
               st_next.busy = 1'b0;
               unique case (st_reg.op)
                  OP_CODE: mem_we = 1'b1;
                  OP_LOCK1: st_next.lock_bit_one = 1'b1;
                  OP_LOCK2: st_next.lock_bit_two = 1'b1;
                  default: mem_we = 1'b0;
               endcase
            end
         end
      endcase

      // read modes
      rd_code = f.rst_pin & ~f.vpp_pin & f.strobe_n & (f.mode == `FP_MODE_READ);
      rd_sig = f.rst_pin & ~f.vpp_pin & f.strobe_n & (f.mode == `FP_MODE_SIG);
      locked_any = st_reg.lock_bit_one | st_reg.lock_bit_two;
      st_next.doe = rd_code | rd_sig;
      st_next.dout = `FP_BLANK_BYTE;
      if (rd_code)
      begin
         if (locked_any)
         begin
            st_next.dout = `FP_BLANK_BYTE;
         end
         else if (st_reg.busy && st_reg.addr == st_reg.waddr)
         begin
            st_next.dout = {~st_reg.wdata[7], mem_rd[6:0]};
         end
         else
         begin
            st_next.dout = mem_rd;
         end
      end
      else if (rd_sig)
      begin
         if (st_reg.addr == `FP_SIG_MAKER_ADDR)
         begin
            st_next.dout = MAKER_CODE;
         end
         else if (st_reg.addr == `FP_SIG_PART_ADDR)
         begin
            st_next.dout = PART_CODE;
         end
         else if (st_reg.addr == `FP_SIG_EXTRA_ADDR)
         begin
            st_next.dout = EXTRA_CODE;
         end
      end
   end

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------
   // code array, programming only clears bits
   // ---------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RST || mem_erase)
      begin
         for (int i = 0; i < `FP_ARRAY_BYTES; i++)
         begin
            mem[i] <= `FP_BLANK_BYTE;
         end
      end
      else if (mem_we)
      begin
         mem[st_reg.waddr] <= mem[st_reg.waddr] & st_reg.wdata;
      end
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign LINK.ready_busy_n = ~st_reg.busy;
   assign LINK.data_d2p = st_reg.dout;
   assign LINK.data_d2p_oe = st_reg.doe;
   assign O_BUSY = st_reg.busy;

endmodule // flash_program_strobe_n_device

/* File: verilog/flash_program_strobe_n_programmer.sv */
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "flash_program_strobe_n_cfg.svh"
module flash_program_strobe_n_programmer
#(
   parameter int ERASE_HOLD_CYCLES = `FP_ERASE_CYC + `FP_STEP_CYC
)
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   fp_link_if.programmer LINK
);
   import flash_program_strobe_n_pkg::*;

   // ---------------------------------------------------------
   // declarations
   // ---------------------------------------------------------
   prg_s st_reg;
   prg_s st_next;
   logic [8:0] agree;
   logic hit_cmd;
   logic accept;
   logic done;
   logic program_op;

   assign hit_cmd = I_AVS_WRITE && I_AVS_ADDRESS == `FP_REG_CMD;
   assign accept = hit_cmd && st_reg.state == PS_IDLE;
   assign done = st_reg.cnt == 32'h00000000;
   assign program_op = st_reg.cmd == CMD_WRITE_CODE || st_reg.cmd == CMD_WRITE_LOCK1 ||
      st_reg.cmd == CMD_WRITE_LOCK2 || st_reg.cmd == CMD_ERASE;

   // ---------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = {LINK.ready_busy_n, LINK.data_line};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      agree = ~(st_reg.s2 ^ st_reg.s3);
      st_next.filt = (agree & st_reg.s3) | (~agree & st_reg.filt);
      if (!done)
      begin
         st_next.cnt = st_reg.cnt - 32'h00000001;
      end

      unique case (st_reg.state)
         PS_IDLE:
         begin
            if (accept)
            begin
               st_next.cmd = cmd_e'(I_AVS_WRITEDATA[3:0]);
               st_next.wdata = I_AVS_WRITEDATA[15:8];
               st_next.state = PS_SETUP;
               st_next.cnt = 32'(`FP_SETUP_CYC);
               st_next.vpp_pin = 1'b0;
               unique case (I_AVS_WRITEDATA[3:0])
                  CMD_POWER_UP:
                  begin
                     st_next.rst_pin = 1'b0;
                     st_next.osc = 1'b0;
                     st_next.strobe_on = 1'b0;
                     st_next.doe = 1'b0;
                  end
                  CMD_WRITE_CODE, CMD_WRITE_LOCK1, CMD_WRITE_LOCK2, CMD_ERASE:
                  begin
                     st_next.mode = I_AVS_WRITEDATA[3:0] == CMD_WRITE_CODE ? `FP_MODE_WRITE :
                        I_AVS_WRITEDATA[3:0] == CMD_WRITE_LOCK1 ? `FP_MODE_LOCK1 :
                        I_AVS_WRITEDATA[3:0] == CMD_WRITE_LOCK2 ? `FP_MODE_LOCK2 :
                        `FP_MODE_ERASE;
                     st_next.doe = 1'b1;
                  end
                  CMD_READ_CODE, CMD_READ_SIG:
                  begin
                     st_next.mode = I_AVS_WRITEDATA[3:0] == CMD_READ_CODE ? `FP_MODE_READ :
                        `FP_MODE_SIG;
                     st_next.doe = 1'b0;
                     st_next.strobe_on = 1'b0;
                  end
                  CMD_INCREMENT:
                  begin
                     st_next.osc = 1'b1;
                     st_next.state = PS_ACTIVE;
                     st_next.cnt = 32'(`FP_STEP_CYC);
                  end
                  CMD_CLEAR_ADDR:
                  begin
                     st_next.rst_pin = 1'b0;
                     st_next.state = PS_ACTIVE;
                     st_next.cnt = 32'(`FP_STEP_CYC);
                  end
                  CMD_POWER_OFF:
                  begin
                     st_next.osc = 1'b0;
                     st_next.state = PS_ACTIVE;
                     st_next.cnt = 32'(`FP_STEP_CYC);
                  end
                  default: st_next.state = PS_IDLE;
               endcase
            end
         end
         PS_SETUP:
         begin
            if (done)
            begin
               if (st_reg.cmd == CMD_POWER_UP)
               begin
                  st_next.rst_pin = 1'b1;
                  st_next.state = PS_HOLD;
                  st_next.cnt = 32'(`FP_SETUP_CYC);
               end
               else if (program_op)
               begin
                  st_next.vpp_pin = 1'b1;
                  st_next.state = PS_ARM;
                  st_next.cnt = 32'(`FP_SETUP_CYC);
               end
               else
               begin
                  st_next.rdata = st_reg.filt[7:0];
                  st_next.state = PS_IDLE;
               end
            end
         end
         PS_ARM:
         begin
            if (done)
            begin
               st_next.strobe_on = 1'b1;
               st_next.state = PS_ACTIVE;
               st_next.cnt = st_reg.cmd == CMD_ERASE ? 32'(ERASE_HOLD_CYCLES) :
                  32'(`FP_PULSE_CYC);
            end
         end
         PS_ACTIVE:
         begin
            if (done)
            begin
               st_next.state = PS_HOLD;
               st_next.cnt = 32'(`FP_STEP_CYC);
               if (program_op)
               begin
                  st_next.strobe_on = 1'b0;
                  st_next.state = PS_WAIT_RDY;
               end
               else if (st_reg.cmd == CMD_INCREMENT)
               begin
                  st_next.osc = 1'b0;
               end
               else if (st_reg.cmd == CMD_CLEAR_ADDR)
               begin
                  st_next.rst_pin = 1'b1;
               end
               else
               begin
                  st_next.rst_pin = 1'b0;
                  st_next.vpp_pin = 1'b0;
               end
            end
         end
         PS_WAIT_RDY:
         begin
            if (done && st_reg.filt[8])
            begin
               st_next.vpp_pin = 1'b0;
               st_next.doe = 1'b0;
               st_next.state = PS_HOLD;
               st_next.cnt = 32'(`FP_SETUP_CYC);
            end
         end
         PS_HOLD:
         begin
            if (done)
            begin
               st_next.state = PS_IDLE;
            end
         end
         default: st_next.state = PS_IDLE;
      endcase
   end

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------
   // bus and pins
   // ---------------------------------------------------------
   assign O_AVS_WAITREQUEST = hit_cmd && st_reg.state != PS_IDLE;
   assign O_AVS_READDATA = !I_AVS_READ ? 32'h00000000 :
      I_AVS_ADDRESS == `FP_REG_CMD ? {16'h0000, st_reg.wdata, 4'h0, st_reg.cmd} :
      I_AVS_ADDRESS == `FP_REG_STATUS ?
      {16'h0000, st_reg.rdata, 6'h00, st_reg.filt[8], st_reg.state != PS_IDLE} :
      32'h00000000;

   assign LINK.rst_pin = st_reg.rst_pin;
   assign LINK.vpp_pin = st_reg.vpp_pin;
   assign LINK.osc_pin = st_reg.osc;
   assign LINK.program_strobe_n = ~st_reg.strobe_on;
   assign LINK.mode_select = st_reg.mode;
   assign LINK.data_p2d = st_reg.wdata;
   assign LINK.data_p2d_oe = st_reg.doe;

endmodule // flash_program_strobe_n_programmer

/* File: verif/flash_program_strobe_n_assertions.sv */
`timescale 1ns/100ps
module flash_program_strobe_n_assertions
#(
   parameter int WRITE_CYCLES = 40
)
(
   input logic I_CLK,
   input logic I_RST,
   input logic rst_pin,
   input logic vpp_pin,
   input logic osc_pin,
   input logic program_strobe_n,
   input logic [3:0] mode_select,
   input logic [7:0] data_p2d,
   input logic data_d2p_oe,
   input logic ready_busy_n
);
   logic [31:0] lo_cnt;
   logic [15:0] hi_cnt;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   // ---------------------------------------------------------
   // helper counters
   // ---------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      lo_cnt <= ready_busy_n ? 32'h0 : lo_cnt + 32'h1;
      hi_cnt <= osc_pin ? hi_cnt + 16'h1 : 16'h0;
   end

   // ---------------------------------------------------------
   // link properties
   // ---------------------------------------------------------
   property p_busy_len; $rose(ready_busy_n) |-> lo_cnt == WRITE_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
   property p_busy_cause; $fell(ready_busy_n) |-> program_strobe_n && !$past(program_strobe_n, 8);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without strobe");
   property p_busy_start;
      $rose(program_strobe_n) && vpp_pin && (mode_select == 4'hf || mode_select == 4'h3)
         |-> ##[1:8] !ready_busy_n;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("write not started");
   property p_oe_mode;
      $rose(data_d2p_oe) |-> rst_pin && !vpp_pin && (mode_select == 4'hc || mode_select == 4'h0);
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("port driven outside read");
   property p_oe_off; !rst_pin [*8] |-> !data_d2p_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("port driven in reset");
   property p_mode_hold; !program_strobe_n && vpp_pin |=> $stable(mode_select); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved in strobe");
   property p_data_hold; !program_strobe_n && vpp_pin |=> $stable(data_p2d); endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved in strobe");
   property p_rst_rise; $rose(rst_pin) |-> program_strobe_n && !osc_pin; endproperty
   a_rst_rise: assert property (p_rst_rise) else $error("bad power up order");
   property p_rst_fall; $fell(rst_pin) |-> !osc_pin && !$past(osc_pin); endproperty
   a_rst_fall: assert property (p_rst_fall) else $error("bad power off order");
   property p_osc_width; $fell(osc_pin) |-> hi_cnt >= 16'h32 && ready_busy_n; endproperty
   a_osc_width: assert property (p_osc_width) else $error("increment pulse short");
endmodule // flash_program_strobe_n_assertions

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
   import flash_program_strobe_n_pkg::*;
   localparam logic [7:0] MAKER = 8'h12; // arbitrary value
   localparam logic [7:0] PART = 8'h34; // arbitrary value
   localparam logic [7:0] EXTRA = 8'h56; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] rd;
   logic [7:0] sig [3] = '{MAKER, PART, EXTRA};
   int err_total = 0;
   int checked = 0;
   int busy_starts = 0;
   logic dev_busy;
   logic busy_q = 1'b0;
   fp_link_if link();
   always #2 clk = ~clk;

   flash_program_strobe_n_device #(.WRITE_CYCLES(40), .ERASE_CYCLES(100), .MAKER_CODE(MAKER),
      .PART_CODE(PART), .EXTRA_CODE(EXTRA)) u_flash_program_strobe_n_device (.I_CLK(clk), .I_RST(rst),
      .LINK(link.device), .O_BUSY(dev_busy));
   flash_program_strobe_n_programmer #(.ERASE_HOLD_CYCLES(150)) u_flash_program_strobe_n_programmer (.I_CLK(clk),
      .I_RST(rst), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
      .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
      .O_AVS_READDATA(avs_readdata), .O_AVS_WAITREQUEST(avs_waitrequest),
      .LINK(link.programmer));
   flash_program_strobe_n_assertions #(.WRITE_CYCLES(40)) u_flash_program_strobe_n_assertions (.I_CLK(clk),
      .I_RST(rst), .rst_pin(link.rst_pin), .vpp_pin(link.vpp_pin), .osc_pin(link.osc_pin),
      .program_strobe_n(link.program_strobe_n), .mode_select(link.mode_select),
      .data_p2d(link.data_p2d), .data_d2p_oe(link.data_d2p_oe),
      .ready_busy_n(link.ready_busy_n));

   always @(posedge clk)
   begin
      busy_q <= dev_busy;
      if (dev_busy === 1'b1 && busy_q !== 1'b1)
      begin
         busy_starts++;
      end
   end

   // ---------------------------------------------------------
   // bus and check tasks
   // ---------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cmd(input cmd_e c, input logic [7:0] b);
      avs_address <= 4'h0;
      avs_writedata <= {16'h0, b, 4'h0, c};
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      do av_rd(4'h4, rd); while (rd[0] !== 1'b0);
   endtask

   task automatic rb(input cmd_e c, input logic [7:0] exp, input string what);
      cmd(c, 8'h0);
      chk(what, {24'h0, exp}, {24'h0, rd[15:8]});
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------
   // tests
   // ---------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      av_rd(4'h8, rd);
      chk("unmapped read", 32'h0, rd);
      cmd(CMD_POWER_UP, 8'h0);
      chk("ready level", 32'h1, {31'h0, rd[1]});
      rb(CMD_READ_CODE, 8'hff, "blank byte");
      $display("test blank done");
      cmd(CMD_WRITE_CODE, 8'ha5);
      rb(CMD_READ_CODE, 8'ha5, "byte 0");
      cmd(CMD_INCREMENT, 8'h0);
      cmd(CMD_WRITE_CODE, 8'h3c);
      rb(CMD_READ_CODE, 8'h3c, "byte 1");
      cmd(CMD_CLEAR_ADDR, 8'h0);
      rb(CMD_READ_CODE, 8'ha5, "byte 0 again");
      $display("test program done");
      cmd(CMD_CLEAR_ADDR, 8'h0);
      for (int i = 0; i < 3; i++)
      begin
         rb(CMD_READ_SIG, sig[i], "signature");
         cmd(CMD_INCREMENT, 8'h0);
      end
      $display("test signature done");
      cmd(CMD_CLEAR_ADDR, 8'h0);
      cmd(CMD_WRITE_LOCK1, 8'h0);
      rb(CMD_READ_CODE, 8'hff, "locked read");
      cmd(CMD_WRITE_CODE, 8'h00);
      chk("busy starts", 32'h3, busy_starts);
      cmd(CMD_WRITE_LOCK2, 8'h0);
      cmd(CMD_ERASE, 8'h0);
      rb(CMD_READ_CODE, 8'hff, "erased byte");
      cmd(CMD_WRITE_CODE, 8'h77);
      rb(CMD_READ_CODE, 8'h77, "rewritten byte");
      cmd(CMD_POWER_OFF, 8'h0);
      $display("test lock and erase done");
      give_verdict();
   end

   initial
   begin
      #396000;
      err_total++;
      give_verdict();
   end
endmodule // testbench
